// ==== rcs_pkg.sv ====
package rcs_pkg;
    localparam int NUM_CH = 64;
    localparam int NUM_TREE = 5;
    localparam int NUM_RELAY = NUM_CH + NUM_TREE;
    localparam int LIST_DEPTH = 128;
    localparam int LIST_AW = 7;
    localparam logic [6:0] CH_LAST = 7'h3f;
    localparam logic [6:0] CH_BANK_A_LAST = 7'h1f;
    localparam logic [6:0] BANK_B_OFFSET = 7'h20;
    localparam logic [6:0] CODE_TREE_FIRST = 7'h5a;
    localparam logic [6:0] CODE_TREE_LAST = 7'h5e;
    localparam logic [6:0] CODE_ALL = 7'h63;
    localparam int IDX_A_SENSE = 64;
    localparam int IDX_B_SENSE = 65;
    localparam int IDX_B_SOURCE = 66;
    localparam int IDX_THERM_A = 67;
    localparam int IDX_THERM_B = 68;
    localparam logic [6:0] CARD_MAX = 7'h63;
    localparam int RELAY_SETTLE_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SETTLE_CYCLES =
        (RELAY_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);

    typedef enum logic [2:0] {
        RCS_OP_CLOSE, RCS_OP_OPEN, RCS_OP_QCLOSED, RCS_OP_QOPEN,
        RCS_OP_SCAN_DEF, RCS_OP_INIT, RCS_OP_TRIG, RCS_OP_ABORT
    } rcs_op_t;

    typedef enum logic [1:0] {
        RCS_MODE_NONE, RCS_MODE_VOLT, RCS_MODE_RES, RCS_MODE_FOUR_WIRE_OHMS_MODE
    } rcs_mode_t;
endpackage

// ==== rcs_list_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcs_list_mem (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [6:0] wr_data,
    input wire logic [6:0] rd_addr,
    output logic [6:0] rd_data
);
    logic [6:0] mem [0:rcs_pkg::LIST_DEPTH-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ==== rcs_scan_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcs_scan_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic [6:0] card_addr,
    input wire logic cmd_valid,
    input wire rcs_pkg::rcs_op_t cmd_op,
    input wire logic [6:0] cmd_card,
    input wire logic [6:0] cmd_first,
    input wire logic [6:0] cmd_last,
    input wire logic cmd_end,
    input wire rcs_pkg::rcs_mode_t scan_mode,
    input wire logic analog_bus_port,
    input wire logic continuous,
    input wire logic trig_out_enable,
    output logic busy,
    output logic [rcs_pkg::NUM_RELAY-1:0] relay_drive,
    output logic query_valid,
    output logic query_bit,
    output logic cmd_error,
    output logic scan_active,
    output logic scan_trigger_out,
    output logic bank_a_sense_tie,
    output logic bank_b_sense_tie,
    output logic bank_b_source_tie,
    output logic thermistor_bank_a_tie,
    output logic thermistor_bank_b_tie
);
    typedef enum logic [1:0] {
        RCS_IDLE, RCS_WALK, RCS_SETTLE, RCS_FETCH
    } rcs_state_t;

    typedef struct packed {
        rcs_state_t st;
        logic [rcs_pkg::NUM_RELAY-1:0] drive;
        logic [6:0] cur, last, wr_ptr, len, rd_ptr;
        logic [7:0] settle;
        logic level, list_ok, scanning, fetch_pend, whole;
        logic qv, qb, err, tpulse;
    } rcs_s_t;
    rcs_s_t s_reg, s_next;
    logic [6:0] mem_rd;
    logic mem_wr;
    logic [6:0] mem_rd_addr;

    rcs_list_mem u_mem (
        .clk(clk),
        .wr_en(mem_wr),
        .wr_addr(s_reg.wr_ptr),
        .wr_data(cmd_first),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd)
    );

    function automatic int rcs_index(input logic [6:0] code);
        if (code >= rcs_pkg::CODE_TREE_FIRST) begin
            return rcs_pkg::NUM_CH + int'(code - rcs_pkg::CODE_TREE_FIRST);
        end
        return int'(code);
    endfunction

    function automatic logic rcs_tree(input logic [6:0] c);
        return c >= rcs_pkg::CODE_TREE_FIRST && c <= rcs_pkg::CODE_TREE_LAST;
    endfunction

    logic mine, ch_ok, tree_ok, all_code, scan_ok, four_wire_ohms_mode;
    logic [6:0] walk_end, fetch_ch;
    always_comb begin
        mine = cmd_card == card_addr && cmd_card <= rcs_pkg::CARD_MAX;
        ch_ok = cmd_first <= rcs_pkg::CH_LAST && cmd_last <= rcs_pkg::CH_LAST
            && cmd_first <= cmd_last;
        tree_ok = rcs_tree(cmd_first) && rcs_tree(cmd_last)
            && cmd_first <= cmd_last;
        all_code = cmd_last == rcs_pkg::CODE_ALL;
        four_wire_ohms_mode = scan_mode == rcs_pkg::RCS_MODE_FOUR_WIRE_OHMS_MODE;
        scan_ok = (cmd_first <= rcs_pkg::CH_LAST
            && !(four_wire_ohms_mode && cmd_first > rcs_pkg::CH_BANK_A_LAST))
            || cmd_first == rcs_pkg::CODE_ALL;
        walk_end = all_code ? rcs_pkg::CODE_TREE_LAST : cmd_last;
        fetch_ch = s_reg.whole ? s_reg.rd_ptr : mem_rd;
    end
    always_comb begin
        s_next = s_reg;
        s_next.qv = 1'b0;
        s_next.err = 1'b0;
        s_next.tpulse = 1'b0;
        mem_wr = 1'b0;
        mem_rd_addr = s_reg.rd_ptr;
        case (s_reg.st)
            RCS_IDLE: begin
                if (cmd_valid && mine) begin
                    case (cmd_op)
                        rcs_pkg::RCS_OP_CLOSE, rcs_pkg::RCS_OP_OPEN: begin
                            if (ch_ok || tree_ok || (all_code
                                && cmd_first <= rcs_pkg::CH_LAST)) begin
                                s_next.cur = cmd_first;
                                s_next.last = walk_end;
                                s_next.level = cmd_op == rcs_pkg::RCS_OP_CLOSE;
                                s_next.st = RCS_WALK;
                            end else begin
                                s_next.err = 1'b1;
                            end
                        end
                        rcs_pkg::RCS_OP_QCLOSED: begin
                            s_next.qv = 1'b1;
                            s_next.qb = s_reg.drive[rcs_index(cmd_first)];
                        end
                        rcs_pkg::RCS_OP_QOPEN: begin
                            s_next.qv = 1'b1;
                            s_next.qb = !s_reg.drive[rcs_index(cmd_first)];
                        end
                        rcs_pkg::RCS_OP_SCAN_DEF: begin
                            if (cmd_first == rcs_pkg::CODE_ALL) begin
                                // Whole card expands to channel entries
                                s_next.len = four_wire_ohms_mode ? 7'h20 : 7'h40;
                                s_next.whole = 1'b1;
                            end else if (scan_ok && s_reg.list_ok) begin
                                mem_wr = 1'b1;
                                s_next.wr_ptr = s_reg.wr_ptr + 7'h01;
                                s_next.len = s_reg.wr_ptr + 7'h01;
                                s_next.whole = 1'b0;
                            end else begin
                                s_next.list_ok = 1'b0;
                                s_next.err = 1'b1;
                            end
                            if (cmd_end) begin
                                s_next.wr_ptr = 7'h00;
                                if (!s_next.list_ok) begin
                                    s_next.list_ok = 1'b1;
                                    s_next.len = 7'h00;
                                    s_next.whole = 1'b0;
                                end
                            end
                        end
                        rcs_pkg::RCS_OP_INIT: begin
                            if (s_reg.list_ok && s_reg.len != 7'h00) begin
                                s_next.scanning = 1'b1;
                                s_next.rd_ptr = 7'h00;
                                mem_rd_addr = 7'h00;
                                s_next.st = RCS_FETCH;
                            end else begin
                                s_next.err = 1'b1;
                            end
                        end
                        rcs_pkg::RCS_OP_TRIG: begin
                            if (s_reg.scanning) begin
                                s_next.drive[rcs_pkg::NUM_CH-1:0] = '0;
                                if (s_reg.rd_ptr + 7'h01 < s_reg.len) begin
                                    s_next.rd_ptr = s_reg.rd_ptr + 7'h01;
                                    s_next.st = RCS_FETCH;
                                end else if (continuous) begin
                                    s_next.rd_ptr = 7'h00;
                                    s_next.st = RCS_FETCH;
                                end else begin
                                    s_next.scanning = 1'b0;
                                end
                                mem_rd_addr = s_next.rd_ptr;
                            end
                        end
                        rcs_pkg::RCS_OP_ABORT: begin
                            s_next.scanning = 1'b0;
                        end
                        default: begin
                            s_next.err = 1'b1;
                        end
                    endcase
                end
            end
            RCS_WALK: begin
                if (s_reg.cur <= rcs_pkg::CH_LAST || rcs_tree(s_reg.cur)) begin
                    s_next.drive[rcs_index(s_reg.cur)] = s_reg.level;
                end
                s_next.settle = 8'h00;
                s_next.st = RCS_SETTLE;
            end
            RCS_SETTLE: begin
                if (s_reg.settle != rcs_pkg::SETTLE_LAST) begin
                    s_next.settle = s_reg.settle + 8'h01;
                end else if (s_reg.cur >= s_reg.last) begin
                    s_next.st = RCS_IDLE;
                end else begin
                    s_next.cur = s_reg.cur == rcs_pkg::CH_LAST
                        ? rcs_pkg::CODE_TREE_FIRST : s_reg.cur + 7'h01;
                    s_next.st = RCS_WALK;
                end
            end
            RCS_FETCH: begin
                // Register holds entry; a 99 list reads as the index
                if (s_reg.fetch_pend) begin
                    s_next.fetch_pend = 1'b0;
                    s_next.drive[fetch_ch] = 1'b1;
                    if (four_wire_ohms_mode) begin
                        s_next.drive[fetch_ch + rcs_pkg::BANK_B_OFFSET]
                            = 1'b1;
                    end
                    s_next.tpulse = trig_out_enable;
                    s_next.st = RCS_IDLE;
                end else begin
                    s_next.fetch_pend = 1'b1;
                end
            end
            default: begin
                s_next.st = RCS_IDLE;
            end
        endcase
        if (s_reg.scanning) begin
            // Tree follows port and mode while scanning
            s_next.drive[rcs_pkg::NUM_RELAY-1:rcs_pkg::NUM_CH] = {
                1'b0, 1'b0, analog_bus_port && four_wire_ohms_mode,
                analog_bus_port && four_wire_ohms_mode, analog_bus_port};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.list_ok <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = s_reg.st != RCS_IDLE;
    assign relay_drive = s_reg.drive;
    assign query_valid = s_reg.qv;
    assign query_bit = s_reg.qb;
    assign cmd_error = s_reg.err;
    assign scan_active = s_reg.scanning;
    assign scan_trigger_out = s_reg.tpulse;
    assign bank_a_sense_tie = s_reg.drive[rcs_pkg::IDX_A_SENSE];
    assign bank_b_sense_tie = s_reg.drive[rcs_pkg::IDX_B_SENSE];
    assign bank_b_source_tie = s_reg.drive[rcs_pkg::IDX_B_SOURCE];
    assign thermistor_bank_a_tie = s_reg.drive[rcs_pkg::IDX_THERM_A];
    assign thermistor_bank_b_tie = s_reg.drive[rcs_pkg::IDX_THERM_B];

    reset_open_a: assert property (@(posedge clk)
        reset |=> relay_drive == '0)
        else $error("relays not open after reset");
    query_close_a: assert property (@(posedge clk) disable iff (reset)
        cmd_valid && !busy && mine && cmd_op == rcs_pkg::RCS_OP_QCLOSED
        && cmd_first <= rcs_pkg::CH_LAST
        |=> query_valid && query_bit == $past(relay_drive[cmd_first[5:0]]))
        else $error("closed query wrong");
    query_open_a: assert property (@(posedge clk) disable iff (reset)
        cmd_valid && !busy && mine && cmd_op == rcs_pkg::RCS_OP_QOPEN
        && cmd_first <= rcs_pkg::CH_LAST
        |=> query_valid && query_bit != $past(relay_drive[cmd_first[5:0]]))
        else $error("open query wrong");
    bad_open_a: assert property (@(posedge clk) disable iff (reset)
        cmd_valid && !busy && mine && cmd_op == rcs_pkg::RCS_OP_OPEN
        && cmd_first > rcs_pkg::CODE_TREE_LAST && cmd_first < rcs_pkg::CODE_ALL
        |=> cmd_error && !busy)
        else $error("open of 95-98 not flagged");
    one_step_a: assert property (@(posedge clk) disable iff (reset)
        busy && !scan_active |-> $countones(relay_drive ^ $past(relay_drive)) <= 1)
        else $error("more than one relay moved");
    trig_pulse_a: assert property (@(posedge clk) disable iff (reset)
        scan_trigger_out |-> scan_active && !$past(scan_trigger_out))
        else $error("trigger pulse too long");
    four_wire_ohms_mode_pair_a: assert property (@(posedge clk) disable iff (reset)
        scan_trigger_out && scan_mode == rcs_pkg::RCS_MODE_FOUR_WIRE_OHMS_MODE
        |-> (relay_drive[31:0] & ~$past(relay_drive[31:0])
        & ~relay_drive[63:32]) == 32'h0)
        else $error("four-wire pair missing");
    tree_scan_a: assert property (@(posedge clk) disable iff (reset)
        scan_active && $past(scan_active) && !analog_bus_port
        && $past(!analog_bus_port) |-> !bank_a_sense_tie && !bank_b_source_tie)
        else $error("tree closed without port");
    stop_scan_a: assert property (@(posedge clk) disable iff (reset)
        cmd_valid && !busy && mine && cmd_op == rcs_pkg::RCS_OP_TRIG
        && scan_active && !continuous && s_reg.rd_ptr + 7'h01 >= s_reg.len
        |=> !scan_active && relay_drive[63:0] == '0)
        else $error("scan did not stop at end");
    close_cov: cover property (@(posedge clk) busy ##[1:40] !busy);
    scan_cov: cover property (@(posedge clk) scan_trigger_out ##[1:50]
        scan_trigger_out);
    err_cov: cover property (@(posedge clk) cmd_error);
endmodule
`default_nettype wire

// ==== rcs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcs_host (
    input wire logic clk,
    input wire logic busy,
    output logic cmd_valid,
    output rcs_pkg::rcs_op_t cmd_op,
    output logic [6:0] cmd_card,
    output logic [6:0] cmd_first,
    output logic [6:0] cmd_last,
    output logic cmd_end
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op = rcs_pkg::RCS_OP_CLOSE;
        cmd_card = 7'h00;
        cmd_first = 7'h00;
        cmd_last = 7'h00;
        cmd_end = 1'b0;
    end
    // Waits for an idle device unless told to push into a busy one
    task automatic issue(input rcs_pkg::rcs_op_t op, input logic [6:0] card,
        input logic [6:0] f, input logic [6:0] l, input logic e, input bit now);
        int n;
        n = 0;
        if (!now) begin
            repeat (2) @(posedge clk);
        end
        @(posedge clk);
        while (!now && busy !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_card <= card;
        cmd_first <= f;
        cmd_last <= l;
        cmd_end <= e;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // Qualifiers go stale once the strobe drops
        cmd_card <= ~card;
        cmd_first <= ~f;
        cmd_last <= ~l;
        cmd_end <= ~e;
    endtask
endmodule
`default_nettype wire

// ==== relay_channel_scan_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module relay_channel_scan_control_tb;
    typedef struct {
        rcs_pkg::rcs_op_t op;
        logic [6:0] card, f, l;
        logic [63:0] ch;
        logic [4:0] tr;
        logic q;
        int err;
    } rcs_row_t;
    logic clk, reset, analog_bus_port, continuous, trig_out_enable;
    logic [6:0] card_addr;
    rcs_pkg::rcs_mode_t scan_mode;
    logic cmd_valid, cmd_end, busy, query_valid, query_bit, cmd_error;
    rcs_pkg::rcs_op_t cmd_op;
    logic [6:0] cmd_card, cmd_first, cmd_last;
    logic [68:0] relay_drive;
    logic scan_active, scan_trigger_out, bank_a_sense_tie, bank_b_sense_tie;
    logic bank_b_source_tie, thermistor_bank_a_tie, thermistor_bank_b_tie;
    logic q_bit;
    int bad_count, tests_run, err_cnt, trig_cnt, e0, t0;
    rcs_row_t rows [12];
    rcs_host host (.clk(clk), .busy(busy), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_card(cmd_card), .cmd_first(cmd_first),
        .cmd_last(cmd_last), .cmd_end(cmd_end));
    rcs_scan_ctrl dut (.clk(clk), .reset(reset), .card_addr(card_addr),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_card(cmd_card),
        .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_end(cmd_end),
        .scan_mode(scan_mode), .analog_bus_port(analog_bus_port),
        .continuous(continuous), .trig_out_enable(trig_out_enable),
        .busy(busy), .relay_drive(relay_drive), .query_valid(query_valid),
        .query_bit(query_bit), .cmd_error(cmd_error),
        .scan_active(scan_active), .scan_trigger_out(scan_trigger_out),
        .bank_a_sense_tie(bank_a_sense_tie),
        .bank_b_sense_tie(bank_b_sense_tie),
        .bank_b_source_tie(bank_b_source_tie),
        .thermistor_bank_a_tie(thermistor_bank_a_tie),
        .thermistor_bank_b_tie(thermistor_bank_b_tie));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cmd_error === 1'b1) err_cnt++;
        if (scan_trigger_out === 1'b1) trig_cnt++;
        if (query_valid === 1'b1) q_bit = query_bit;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check_drive(input logic [63:0] ch, input logic [4:0] tr);
        tests_run++;
        if (relay_drive !== {tr, ch} || {thermistor_bank_b_tie,
            thermistor_bank_a_tie, bank_b_source_tie, bank_b_sense_tie,
            bank_a_sense_tie} !== tr) begin
            bad_count++;
            $display("MISMATCH t=%0t relay state %h", $time, relay_drive);
        end
    endtask
    task automatic check_bit(input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t flag %b", $time, g);
        end
    endtask
    task automatic check_cnt(input int e, input int g);
        tests_run++;
        if (g != e) begin
            bad_count++;
            $display("MISMATCH t=%0t count %0d", $time, g);
        end
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        while (busy !== 1'b0 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        #1;
    endtask
    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1;
    endtask
    task automatic cmd(input rcs_pkg::rcs_op_t op, input logic [6:0] f,
        input logic [6:0] l, input logic e);
        host.issue(op, 7'h01, f, l, e, 1'b0);
    endtask
    task automatic step(input rcs_pkg::rcs_op_t op, input logic [63:0] ch,
        input logic [4:0] tr);
        cmd(op, 7'h00, 7'h00, 1'b0);
        repeat (4) @(posedge clk);
        #1;
        check_drive(ch, tr);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end
    initial begin
        reset = 1'b1;
        card_addr = 7'h01;
        scan_mode = rcs_pkg::RCS_MODE_NONE;
        analog_bus_port = 1'b0;
        continuous = 1'b0;
        trig_out_enable = 1'b1;
        bad_count = 0;
        tests_run = 0;
        err_cnt = 0;
        trig_cnt = 0;
        rows[0] = '{rcs_pkg::RCS_OP_CLOSE, 7'h01, 7'h05, 7'h06, 64'h60, 5'h00,
            1'b0, 0};
        rows[1] = '{rcs_pkg::RCS_OP_CLOSE, 7'h01, 7'h5a, 7'h5e, 64'h60, 5'h1f,
            1'b0, 0};
        rows[2] = '{rcs_pkg::RCS_OP_OPEN, 7'h01, 7'h5f, 7'h5f, 64'h60, 5'h1f,
            1'b0, 1};
        rows[3] = '{rcs_pkg::RCS_OP_OPEN, 7'h01, 7'h5b, 7'h5b, 64'h60, 5'h1d,
            1'b0, 0};
        rows[4] = '{rcs_pkg::RCS_OP_CLOSE, 7'h03, 7'h00, 7'h00, 64'h60, 5'h1d,
            1'b0, 0};
        rows[5] = '{rcs_pkg::RCS_OP_CLOSE, 7'h01, 7'h00, 7'h63, '1, 5'h1f,
            1'b0, 0};
        rows[6] = '{rcs_pkg::RCS_OP_OPEN, 7'h01, 7'h28, 7'h63,
            64'h0000_00ff_ffff_ffff, 5'h00, 1'b0, 0};
        rows[7] = '{rcs_pkg::RCS_OP_CLOSE, 7'h01, 7'h3f, 7'h3f,
            64'h8000_00ff_ffff_ffff, 5'h00, 1'b0, 0};
        rows[8] = rows[7];
        rows[8].op = rcs_pkg::RCS_OP_QCLOSED;
        rows[8].q = 1'b1;
        rows[9] = rows[8];
        rows[9].f = 7'h2d;
        rows[9].q = 1'b0;
        rows[10] = rows[9];
        rows[10].op = rcs_pkg::RCS_OP_QOPEN;
        rows[10].q = 1'b1;
        rows[11] = rows[10];
        rows[11].f = 7'h00;
        rows[11].q = 1'b0;
        do_reset();
        check_drive('0, 5'h00);
        check_bit(1'b0, busy);
        foreach (rows[i]) begin
            e0 = err_cnt;
            q_bit = 1'bx;
            host.issue(rows[i].op, rows[i].card, rows[i].f, rows[i].l, 1'b0,
                1'b0);
            wait_idle();
            check_drive(rows[i].ch, rows[i].tr);
            if (rows[i].op inside {rcs_pkg::RCS_OP_QCLOSED,
                rcs_pkg::RCS_OP_QOPEN}) check_bit(rows[i].q, q_bit);
            check_cnt(rows[i].err, err_cnt - e0);
        end
        do_reset();
        // A request pushed while busy must be dropped
        cmd(rcs_pkg::RCS_OP_CLOSE, 7'h0a, 7'h0c, 1'b0);
        host.issue(rcs_pkg::RCS_OP_CLOSE, 7'h01, 7'h14, 7'h14, 1'b0, 1'b1);
        wait_idle();
        check_drive(64'h1c00, 5'h00);
        cmd(rcs_pkg::RCS_OP_CLOSE, 7'h00, 7'h63, 1'b0);
        repeat (20) @(posedge clk);
        check_bit(1'b1, busy);
        do_reset();
        check_drive('0, 5'h00);
        t0 = trig_cnt;
        cmd(rcs_pkg::RCS_OP_SCAN_DEF, 7'h03, 7'h03, 1'b0);
        cmd(rcs_pkg::RCS_OP_SCAN_DEF, 7'h3e, 7'h3e, 1'b1);
        step(rcs_pkg::RCS_OP_INIT, 64'h8, 5'h00);
        check_cnt(1, trig_cnt - t0);
        step(rcs_pkg::RCS_OP_TRIG, 64'h4000_0000_0000_0000, 5'h00);
        step(rcs_pkg::RCS_OP_TRIG, '0, 5'h00);
        check_bit(1'b0, scan_active);
        check_cnt(2, trig_cnt - t0);
        continuous <= 1'b1;
        trig_out_enable <= 1'b0;
        step(rcs_pkg::RCS_OP_INIT, 64'h8, 5'h00);
        step(rcs_pkg::RCS_OP_TRIG, 64'h4000_0000_0000_0000, 5'h00);
        step(rcs_pkg::RCS_OP_TRIG, 64'h8, 5'h00);
        check_cnt(2, trig_cnt - t0);
        cmd(rcs_pkg::RCS_OP_ABORT, 7'h00, 7'h00, 1'b0);
        wait_idle();
        check_bit(1'b0, scan_active);
        trig_out_enable <= 1'b1;
        do_reset();
        e0 = err_cnt;
        cmd(rcs_pkg::RCS_OP_SCAN_DEF, 7'h5c, 7'h5c, 1'b1);
        cmd(rcs_pkg::RCS_OP_SCAN_DEF, 7'h40, 7'h40, 1'b1);
        wait_idle();
        check_cnt(2, err_cnt - e0);
        cmd(rcs_pkg::RCS_OP_SCAN_DEF, 7'h63, 7'h63, 1'b1);
        step(rcs_pkg::RCS_OP_INIT, 64'h1, 5'h00);
        step(rcs_pkg::RCS_OP_TRIG, 64'h2, 5'h00);
        do_reset();
        scan_mode <= rcs_pkg::RCS_MODE_FOUR_WIRE_OHMS_MODE;
        analog_bus_port <= 1'b1;
        cmd(rcs_pkg::RCS_OP_CLOSE, 7'h5c, 7'h5c, 1'b0);
        e0 = err_cnt;
        cmd(rcs_pkg::RCS_OP_SCAN_DEF, 7'h21, 7'h21, 1'b1);
        wait_idle();
        check_cnt(1, err_cnt - e0);
        cmd(rcs_pkg::RCS_OP_SCAN_DEF, 7'h02, 7'h02, 1'b1);
        step(rcs_pkg::RCS_OP_INIT, 64'h4_0000_0004, 5'h07);
        test_done();
    end
endmodule
`default_nettype wire
